// *** burst_sram_defs.svh ***
`ifndef BURST_SRAM_DEFS_SVH
`define BURST_SRAM_DEFS_SVH

// ************************************************************
// Array geometry
// ************************************************************
`define SRAM_WORDS 32768
`define SRAM_ADDR_W 15
`define SRAM_WORD_W 18
`define SRAM_BYTE_W 9
`define SRAM_LOW_BYTE_LSB 0
`define SRAM_HIGH_BYTE_LSB 9

// ************************************************************
// Burst counter
// ************************************************************
`define BURST_CNT_W 2
`define BURST_CNT_RESET 2'h0
`define BURST_CNT_STEP 2'h1

`endif

// *** burst_sram_pkg.sv ***
`include "burst_sram_defs.svh"

package burst_sram_pkg;

	// Sampled bus pins, all active-low controls
	typedef struct packed {
		logic procStrobe_n;
		logic ctrlStrobe_n;
		logic step_n;
		logic lowWrite_n;
		logic highWrite_n;
		logic chipSel_n;
		logic [`SRAM_ADDR_W-1:0] addr;
		logic [`SRAM_WORD_W-1:0] data;
	} bus_sample_t;

	// Operation decoded for one clock
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_READ,
		OP_WRITE,
		OP_DESELECT
	} sram_op_t;

endpackage

// *** read_sink.sv ***
`timescale 1ns/1ps

module read_sink (
	input wire logic clock,
	input wire logic rst,
	input wire logic stall,
	input wire logic readValid,
	input wire logic [17:0] dataOut,
	output logic readAccept
);
	logic [17:0] got [$];
	// Accept is registered, so a stall takes hold one edge late, like a real receiver
	always @(posedge clock) begin
		readAccept <= !rst && !stall;
		if (readValid && readAccept) begin
			got.push_back(dataOut);
		end
	end
endmodule

// *** sync_burst_sram_control.sv ***
// Behaviour
// - Array holds 32768 words of 18 bits, addressed by 15 bits.
// - Address, data and controls except output enable are registered each rising edge.
// - Burst keeps upper address bits; 2-bit counter steps low bits, wraps after four.
// - Writes happen on the edge after the sampling edge and finish internally, no external pulse.
// - Low write enable gates bits 0..8, high gates bits 9..17.
// - Processor strobe with chip select aborts burst and starts a read.
// - With chip select and controller strobe inactive, processor strobe is ignored.
// - Controller strobe with chip select starts read or write at new address.
// - Chip select matters only when loading a base address.
// - Advance input increments burst address before that cycle's access.
// - No strobes and no advance repeats current address as a wait state.
// - Data output drive follows output enable combinationally; writes and deselects float.
// - Outputs stay high impedance from reset until an enabled read.
`timescale 1ns/1ps
`include "burst_sram_defs.svh"

module sync_burst_sram_control
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int WORD_W = `SRAM_WORD_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic low_byte_write_n,
	input wire logic high_byte_write_n,
	input wire logic chipSelect_n,
	input wire logic outputEnable_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [WORD_W-1:0] dataIn,
	output logic [WORD_W-1:0] dataOut,
	output logic dataOutEn_n,
	output logic readValid,
	input wire logic readAccept,
	output logic readRoom
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	initial begin
		if (ADDR_W != `SRAM_ADDR_W || WORD_W != `SRAM_WORD_W) begin
			$error("sync_burst_sram_control: only 15-bit address, 18-bit word supported");
		end
	end

	localparam int DEPTH = `SRAM_WORDS;

	// ************************************************************
	// Input registers
	// ************************************************************
	bus_sample_t sample_q, sample_d;

	// Noninverting capture of every synchronous pin
	always_comb begin
		sample_d.procStrobe_n = proc_addr_strobe_n;
		sample_d.ctrlStrobe_n = ctrl_addr_strobe_n;
		sample_d.step_n = burst_step_n;
		sample_d.lowWrite_n = low_byte_write_n;
		sample_d.highWrite_n = high_byte_write_n;
		sample_d.chipSel_n = chipSelect_n;
		sample_d.addr = address;
		sample_d.data = dataIn;
	end

	// Reset parks the strobes inactive so no access fires after release
	always_ff @(posedge clock) begin
		if (rst) begin
			sample_q <= '{procStrobe_n: 1'b1, ctrlStrobe_n: 1'b1, step_n: 1'b1,
				lowWrite_n: 1'b1, highWrite_n: 1'b1, chipSel_n: 1'b1,
				addr: '0, data: '0};
		end else begin
			sample_q <= sample_d;
		end
	end

	// ************************************************************
	// Burst address and cycle decode
	// ************************************************************
	logic [ADDR_W-1:0] base_q, base_d;
	logic [`BURST_CNT_W-1:0] count_q, count_d;
	logic active_q, active_d;
	sram_op_t op;
	logic anyWrite;
	logic [ADDR_W-1:0] accessAddr;

	always_comb begin
		base_d = base_q;
		count_d = count_q;
		active_d = active_q;
		anyWrite = !sample_q.lowWrite_n || !sample_q.highWrite_n;
		op = OP_IDLE;
		if (!sample_q.procStrobe_n && !sample_q.chipSel_n) begin
			// Abort any burst; read regardless of write enables
			base_d = sample_q.addr;
			count_d = `BURST_CNT_RESET;
			active_d = 1'b1;
			op = OP_READ;
		end else if (!sample_q.ctrlStrobe_n && !sample_q.chipSel_n) begin
			// New base, direction from byte enables
			base_d = sample_q.addr;
			count_d = `BURST_CNT_RESET;
			active_d = 1'b1;
			op = anyWrite ? OP_WRITE : OP_READ;
		end else if (!sample_q.ctrlStrobe_n) begin
			// Controller strobe without select deselects
			active_d = 1'b0;
			op = OP_DESELECT;
		end else if (active_q) begin
			// Continue or suspend, independent of chip select
			// A processor strobe without select lands here: ignored, base kept
			if (!sample_q.step_n) begin
				count_d = count_q + `BURST_CNT_STEP; // Wraps to base after four
			end
			op = anyWrite ? OP_WRITE : OP_READ;
		end else begin
			// No burst open, so continue and suspend cycles do nothing
			op = OP_IDLE;
		end
		// Interleaved order, upper bits fixed
		accessAddr = {base_d[ADDR_W-1:`BURST_CNT_W], base_d[`BURST_CNT_W-1:0] ^ count_d};
	end

	// Burst state registers
	always_ff @(posedge clock) begin
		if (rst) begin
			base_q <= '0;
			count_q <= `BURST_CNT_RESET;
			active_q <= 1'b0;
		end else begin
			base_q <= base_d;
			count_q <= count_d;
			active_q <= active_d;
		end
	end

	// ************************************************************
	// Memory array
	// ************************************************************
	logic [WORD_W-1:0] mem [DEPTH];
	logic readFire;
	logic bufReady;

	// Self-timed write on the edge after sampling; byte lanes gated
	always_ff @(posedge clock) begin
		if (op == OP_WRITE) begin
			if (!sample_q.lowWrite_n) begin
				mem[accessAddr][`SRAM_LOW_BYTE_LSB +: `SRAM_BYTE_W] <=
					sample_q.data[`SRAM_LOW_BYTE_LSB +: `SRAM_BYTE_W];
			end
			if (!sample_q.highWrite_n) begin
				mem[accessAddr][`SRAM_HIGH_BYTE_LSB +: `SRAM_BYTE_W] <=
					sample_q.data[`SRAM_HIGH_BYTE_LSB +: `SRAM_BYTE_W];
			end
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	logic [WORD_W-1:0] readWord_q, readWord_d;
	logic readPend_q, readPend_d;
	logic writing_q, writing_d;
	logic bufValid;
	logic [WORD_W-1:0] bufData;
	logic [2:0] fillNext;

	// Fill the buffer will have when this read's word arrives: held words, plus the one in
	// flight, less the word taken at the next edge. Refusing at two means a word already
	// read never meets a full buffer; a read with no room is dropped instead.
	always_comb begin
		fillNext = {1'b0, !bufReady, bufValid && bufReady} + {2'b00, readPend_q}
			- {2'b00, bufValid && readAccept};
		readFire = (op == OP_READ) && (fillNext < 3'h2);
	end

	always_comb begin
		readWord_d = readFire ? mem[accessAddr] : readWord_q;
		readPend_d = readFire;
		// Drive is blocked on write and deselect cycles
		writing_d = (op == OP_WRITE) || (op == OP_DESELECT);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			readWord_q <= '0;
			readPend_q <= 1'b0;
			writing_q <= 1'b0;
		end else begin
			readWord_q <= readWord_d;
			readPend_q <= readPend_d;
			writing_q <= writing_d;
		end
	end

	// Two words of slack for a stalled receiver; reads issued once held plus in-flight words, less any taken at the next edge, reach two are dropped
	two_entry_buffer #(
		.WIDTH(WORD_W)
	) readBuffer (
		.clock(clock),
		.rst(rst),
		.inValid(readPend_q),
		.inReady(bufReady),
		.inData(readWord_q),
		.outValid(bufValid),
		.outReady(readAccept),
		.outData(bufData)
	);

	assign dataOut = bufData;
	assign readValid = bufValid;
	assign readRoom = bufReady;

	// Output enable acts without the clock; high-Z until a read is held
	assign dataOutEn_n = !(bufValid && !outputEnable_n && !writing_q);

endmodule

// *** sync_burst_sram_control_properties.sv ***
`timescale 1ns/1ps

// ****
// Port checker
// ****
module sync_burst_sram_control_checker
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = 15,
	parameter int WORD_W = 18
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic low_byte_write_n,
	input wire logic high_byte_write_n,
	input wire logic chipSelect_n,
	input wire logic outputEnable_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [WORD_W-1:0] dataIn,
	input wire logic [WORD_W-1:0] dataOut,
	input wire logic dataOutEn_n,
	input wire logic readValid,
	input wire logic readAccept,
	input wire logic readRoom
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Reset state must show even while reset is still held
	property p_reset; disable iff (1'b0) rst |=> dataOutEn_n && !readValid && readRoom; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_quiet; $fell(rst) |-> !readValid [*3]; endproperty
	a_quiet: assert property (p_quiet) else $error("word after reset");
	property p_oe; outputEnable_n |-> dataOutEn_n; endproperty
	a_oe: assert property (p_oe) else $error("drive without enable");
	property p_empty; !readValid |-> dataOutEn_n; endproperty
	a_empty: assert property (p_empty) else $error("drive with no word");
	// A new word can only come from a read cycle three edges back
	property p_src; $rose(readValid) |-> $past(!proc_addr_strobe_n ||
		(low_byte_write_n && high_byte_write_n), 3); endproperty
	a_src: assert property (p_src) else $error("word from write cycle");
	property p_desel; $rose(readValid) |-> !$past(!ctrl_addr_strobe_n && chipSelect_n &&
		proc_addr_strobe_n, 3); endproperty
	a_desel: assert property (p_desel) else $error("word from deselect");
	property p_read; !proc_addr_strobe_n && !chipSelect_n && readRoom && !readValid |-> ##3 readValid;
	endproperty
	a_read: assert property (p_read) else $error("processor read lost");
	property p_hold; readValid && !readAccept |=> readValid && $stable(dataOut); endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");
	property p_full; !readRoom |-> readValid; endproperty
	a_full: assert property (p_full) else $error("full but empty");
endmodule

bind sync_burst_sram_control sync_burst_sram_control_checker #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) chk (
	.clock(clock), .rst(rst), .proc_addr_strobe_n(proc_addr_strobe_n),
	.ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
	.low_byte_write_n(low_byte_write_n), .high_byte_write_n(high_byte_write_n),
	.chipSelect_n(chipSelect_n), .outputEnable_n(outputEnable_n), .address(address),
	.dataIn(dataIn), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .readValid(readValid),
	.readAccept(readAccept), .readRoom(readRoom));

// *** tb_sync_burst_sram_control.sv ***
`timescale 1ns/1ps

module tb_sync_burst_sram_control
	import burst_sram_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic stall = 1'b0;
	logic outputEnable_n = 1'b1;
	bus_sample_t pins = {6'h3F, 15'h0000, 18'h00000};
	logic [17:0] dataOut;
	logic dataOutEn_n, readValid, readAccept, readRoom;
	int num_errors = 0;
	int n_compared = 0;
	logic [17:0] d [4] = '{18'h00011, 18'h08822, 18'h13344, 18'h3CC77};
	logic [17:0] exp [$];
	// Free-running 100 MHz clock
	always #5 clock = ~clock;
	sync_burst_sram_control uut (.clock(clock), .rst(rst), .proc_addr_strobe_n(pins.procStrobe_n),
		.ctrl_addr_strobe_n(pins.ctrlStrobe_n), .burst_step_n(pins.step_n),
		.low_byte_write_n(pins.lowWrite_n), .high_byte_write_n(pins.highWrite_n),
		.chipSelect_n(pins.chipSel_n), .outputEnable_n(outputEnable_n), .address(pins.addr),
		.dataIn(pins.data), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .readValid(readValid),
		.readAccept(readAccept), .readRoom(readRoom));
	read_sink rx (.clock(clock), .rst(rst), .stall(stall), .readValid(readValid),
		.dataOut(dataOut), .readAccept(readAccept));
	task automatic chk(string what, logic [17:0] e, logic [17:0] s);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	// One bus cycle; controls are procS ctrlS step lowW highW sel
	task automatic put(logic [5:0] c, logic [14:0] a, logic [17:0] v);
		@(posedge clock);
		pins <= {c, a, v};
	endtask
	// Extra idle edges expose any word that should never have come
	task automatic drain();
		int k;
		k = 0;
		while (rx.got.size() < exp.size() && k < 60) begin
			@(posedge clock);
			k++;
		end
		repeat (8) @(posedge clock);
		chk("count", 18'(exp.size()), 18'(rx.got.size()));
		foreach (exp[i]) chk("word", exp[i], rx.got[i]);
		exp.delete();
		rx.got.delete();
	endtask
	task automatic t_bytes();
		put(6'h28, 15'h7FFF, 18'h2AAAA);
		put(6'h2A, 15'h7FFF, 18'h15555);
		put(6'h28, 15'h0000, 18'h00000);
		put(6'h2C, 15'h0000, 18'h3FFFF);
		put(6'h2F, 15'h0000, 18'h00000);
		outputEnable_n <= 1'b0;
		put(6'h2E, 15'h7FFF, 18'h00000);
		put(6'h2E, 15'h0000, 18'h00000);
		put(6'h2F, 15'h0000, 18'h00000);
		exp = '{18'h2AB55, 18'h3FE00};
		drain();
	endtask
	task automatic t_burst();
		outputEnable_n <= 1'b1;
		put(6'h28, 15'h0125, d[3]);
		put(6'h1E, 15'h0125, 18'h00000);
		put(6'h39, 15'h0000, d[0]);
		for (int i = 1; i < 4; i++) put(6'h31, 15'h0000, d[i]);
		put(6'h2F, 15'h0000, 18'h00000);
		outputEnable_n <= 1'b0;
		put(6'h1E, 15'h0125, 18'h00000);
		repeat (4) put(6'h37, 15'h0000, 18'h00000);
		put(6'h3F, 15'h0000, 18'h00000);
		put(6'h2F, 15'h0000, 18'h00000);
		exp = '{d[3], d[0], d[1], d[2], d[3], d[0], d[0]};
		drain();
	endtask
	task automatic t_abort();
		put(6'h1E, 15'h0125, 18'h00000);
		put(6'h1F, 15'h7FFF, 18'h00000);
		put(6'h08, 15'h7FFF, 18'h3FFFF);
		put(6'h2E, 15'h0127, 18'h00000);
		put(6'h2E, 15'h7FFF, 18'h00000);
		put(6'h2F, 15'h0000, 18'h00000);
		put(6'h37, 15'h0000, 18'h00000);
		put(6'h3F, 15'h0000, 18'h00000);
		exp = '{d[0], d[0], 18'h2AB55, d[2], 18'h2AB55};
		drain();
	endtask
	// Receiver stalls while a burst overruns the two-entry buffer
	task automatic t_stall();
		@(posedge clock);
		stall <= 1'b1;
		put(6'h1E, 15'h0125, 18'h00000);
		repeat (3) put(6'h37, 15'h0000, 18'h00000);
		put(6'h2F, 15'h0000, 18'h00000);
		// Idle after the deselect, so the held word may drive again
		put(6'h3F, 15'h0000, 18'h00000);
		repeat (6) @(posedge clock);
		#1;
		chk("room", 18'h00000, 18'(readRoom));
		chk("drive", 18'h00000, 18'(dataOutEn_n));
		@(posedge clock);
		outputEnable_n <= 1'b1;
		#1;
		chk("float", 18'h00001, 18'(dataOutEn_n));
		@(posedge clock);
		outputEnable_n <= 1'b0;
		stall <= 1'b0;
		exp = '{d[0], d[1]};
		drain();
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_bytes();
		t_burst();
		t_abort();
		t_stall();
		test_done();
	end
	// Watchdog well beyond the hundred or so cycles the tests need
	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		test_done();
	end
endmodule

// *** two_entry_buffer.sv ***
`timescale 1ns/1ps

module two_entry_buffer
	import burst_sram_pkg::*;
#(
	parameter int WIDTH = 18
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	initial begin
		if (WIDTH < 1) begin
			$error("two_entry_buffer: WIDTH must be at least 1");
		end
	end

	logic [WIDTH-1:0] head_q, head_d;
	logic [WIDTH-1:0] tail_q, tail_d;
	logic [1:0] count_q, count_d;
	logic push, pop;

	// Head is always the oldest word; tail only used when two are held
	always_comb begin
		push = inValid && (count_q != 2'h2);
		pop = outReady && (count_q != 2'h0);
		head_d = head_q;
		tail_d = tail_q;
		count_d = count_q;
		case ({push, pop})
			2'b10: begin
				if (count_q == 2'h0) begin
					head_d = inData;
				end else begin
					tail_d = inData;
				end
				count_d = count_q + 2'h1;
			end
			2'b01: begin
				head_d = tail_q;
				count_d = count_q - 2'h1;
			end
			2'b11: begin
				// One in, one out: the new word becomes head only if it is alone
				if (count_q == 2'h1) begin
					head_d = inData;
				end else begin
					head_d = tail_q;
					tail_d = inData;
				end
			end
			default: begin
				count_d = count_q;
			end
		endcase
	end

	// Registered state; outputs decode only from flops so both sides see clean timing
	always_ff @(posedge clock) begin
		if (rst) begin
			head_q <= '0;
			tail_q <= '0;
			count_q <= 2'h0;
		end else begin
			head_q <= head_d;
			tail_q <= tail_d;
			count_q <= count_d;
		end
	end

	assign outData = head_q;
	assign outValid = (count_q != 2'h0);
	assign inReady = (count_q != 2'h2);

endmodule
